// file: shared/fast_counter_pkg.sv
// Constants and types shared by the fast-mode encoder counter
package fast_counter_pkg;

    // =========================================================
    // Widths
    localparam int COUNT_W = 25;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // =========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] FEEDBACK_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] CONFIG_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] LOAD_VALUE_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] ASSIGN_OFS = 8'h0c;

    // =========================================================
    // Feedback word fields
    localparam int LIFE_BIT = 31;
    localparam int ISO_BIT = 30;
    localparam int PARAM_FAULT_BIT = 29;
    localparam int EXT_FAULT_BIT = 28;
    localparam int INPUT_LEVEL_BIT = 27;
    localparam int DIRECTION_BIT = 26;
    localparam int GATE_BIT = 25;

    // =========================================================
    // Configuration register fields
    localparam int CFG_FUNC_LSB = 0;
    localparam int CFG_GATE_INV_BIT = 2;
    localparam int CFG_EVAL_LSB = 3;
    localparam int CFG_DIR_INV_BIT = 5;
    localparam int CFG_ISO_BIT = 6;
    localparam int CFG_W = 7;
    localparam int ASSIGN_BIT = 0;

    // =========================================================
    // Reset values
    localparam logic [CFG_W-1:0] CONFIG_RESET = 7'h00;
    localparam logic [COUNT_W-1:0] LOAD_VALUE_RESET = 25'h0000000;

    // =========================================================
    // Modes and states
    typedef enum logic [1:0] {
        FUNC_INPUT = 2'h0,
        FUNC_HARDWARE_GATE = 2'h1,
        FUNC_SYNC_EDGE = 2'h2,
        FUNC_SYNC_ENABLE = 2'h3
    } aux_func_t;

    typedef enum logic [1:0] {
        EVAL_SINGLE = 2'h0,
        EVAL_DOUBLE = 2'h1,
        EVAL_QUAD = 2'h2
    } eval_mode_t;

    typedef enum logic {
        GATE_CLOSED = 1'b0,
        GATE_OPEN = 1'b1
    } gate_state_t;

endpackage : fast_counter_pkg

// file: shared/count_step_if.sv
// Count step carrier between quadrature decoder and counter
`timescale 1ns/1ps
`default_nettype none
interface count_step_if;
    logic step;
    logic down;
    modport source (output step, output down);
    modport sink (input step, input down);
endinterface : count_step_if
`default_nettype wire

// file: design/quad_decoder.sv
// Quadrature A/B decoder producing count steps
`timescale 1ns/1ps
`default_nettype none
module quad_decoder (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire fast_counter_pkg::eval_mode_t eval_mode,
    input wire logic dir_invert,
    count_step_if.source steps
);
    import fast_counter_pkg::*;

    // =========================================================
    // Previous levels
    logic prev_a;
    logic prev_b;
    logic step_r;
    logic down_r;
    logic next_step;
    logic next_down;

    always_comb begin
        logic a_rise;
        logic a_edge;
        logic b_edge;
        logic raw_down;
        a_rise = enc_a && !prev_a;
        a_edge = enc_a ^ prev_a;
        b_edge = enc_b ^ prev_b;
        raw_down = 1'b0;
        next_step = 1'b0;
        case (eval_mode)
            EVAL_SINGLE: begin
                next_step = a_rise;
                raw_down = enc_b;
            end
            EVAL_DOUBLE: begin
                next_step = a_edge;
                raw_down = enc_a ~^ enc_b;
            end
            EVAL_QUAD: begin
                // Both edges together are a glitch; skipped rather than guessed
                next_step = a_edge ^ b_edge;
                raw_down = a_edge ? (enc_a ~^ enc_b) : (enc_a ^ enc_b);
            end
            default: begin
                next_step = 1'b0;
                raw_down = 1'b0;
            end
        endcase
        next_down = raw_down ^ dir_invert;
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            step_r <= 1'b0;
            down_r <= 1'b0;
        end else begin
            prev_a <= enc_a;
            prev_b <= enc_b;
            step_r <= next_step;
            down_r <= next_down;
        end
    end

    assign steps.step = step_r;
    assign steps.down = down_r;
endmodule : quad_decoder
`default_nettype wire

// file: design/fast_encoder_counter.sv
// Fast-mode encoder counter with APB feedback and parameter registers
`timescale 1ns/1ps
`default_nettype none
module fast_encoder_counter (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fast_counter_pkg::ADDR_W-1:0] paddr,
    input wire logic [fast_counter_pkg::DATA_W-1:0] pwdata,
    output logic [fast_counter_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_zero,
    input wire logic aux_input,
    input wire logic supply_short,
    input wire logic signal_fault,
    input wire logic iso_sample
);
    import fast_counter_pkg::*;

    // =========================================================
    // Bus decode
    logic setup;
    logic access;
    logic wr_config;
    logic wr_load;
    logic wr_assign;
    logic rd_feedback;

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_config = access && pwrite && (paddr == CONFIG_OFS);
    assign wr_load = access && pwrite && (paddr == LOAD_VALUE_OFS);
    assign wr_assign = access && pwrite && (paddr == ASSIGN_OFS) && pwdata[ASSIGN_BIT];
    assign rd_feedback = setup && !pwrite && (paddr == FEEDBACK_OFS);

    // =========================================================
    // Staged and active parameters
    logic [CFG_W-1:0] config_stage;
    logic [COUNT_W-1:0] load_stage;
    logic [CFG_W-1:0] config_active;
    logic param_fault;
    logic [CFG_W-1:0] next_config_stage;
    logic [COUNT_W-1:0] next_load_stage;
    logic [CFG_W-1:0] next_config_active;
    logic next_param_fault;
    logic stage_invalid;

    aux_func_t func;
    eval_mode_t eval_mode;
    logic gate_invert;
    logic dir_invert;
    logic iso_enable;

    assign func = aux_func_t'(config_active[CFG_FUNC_LSB +: 2]);
    assign eval_mode = eval_mode_t'(config_active[CFG_EVAL_LSB +: 2]);
    assign gate_invert = config_active[CFG_GATE_INV_BIT];
    assign dir_invert = config_active[CFG_DIR_INV_BIT];
    assign iso_enable = config_active[CFG_ISO_BIT];

    always_comb begin
        stage_invalid = config_stage[CFG_GATE_INV_BIT]
            && (config_stage[CFG_FUNC_LSB +: 2] != FUNC_HARDWARE_GATE);
        next_config_stage = config_stage;
        next_load_stage = load_stage;
        next_config_active = config_active;
        next_param_fault = param_fault;
        if (wr_config) begin
            next_config_stage = pwdata[CFG_W-1:0];
        end
        if (wr_load) begin
            next_load_stage = pwdata[COUNT_W-1:0];
        end
        if (wr_assign) begin
            // Faulty set is recorded but not applied; old parameters keep running
            next_param_fault = stage_invalid;
            if (!stage_invalid) begin
                next_config_active = config_stage;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            config_stage <= CONFIG_RESET;
            load_stage <= LOAD_VALUE_RESET;
            config_active <= CONFIG_RESET;
            param_fault <= 1'b0;
        end else begin
            config_stage <= next_config_stage;
            load_stage <= next_load_stage;
            config_active <= next_config_active;
            param_fault <= next_param_fault;
        end
    end

    logic apply_params;
    assign apply_params = wr_assign && !stage_invalid;

    // =========================================================
    // Quadrature decoding
    count_step_if steps ();

    quad_decoder decoder (
        .clk(clk),
        .sys_rst(sys_rst),
        .enc_a(enc_a),
        .enc_b(enc_b),
        .eval_mode(eval_mode),
        .dir_invert(dir_invert),
        .steps(steps.source)
    );

    // =========================================================
    // Gate and input edges
    gate_state_t gate_state;
    gate_state_t next_gate_state;
    logic prev_gate_in;
    logic prev_aux;
    logic prev_zero;
    logic gate_in;
    logic gate_rise;
    logic gate_fall;
    logic counting;
    logic next_prev_gate_in;

    assign gate_in = aux_input ^ gate_invert;
    assign gate_rise = gate_in && !prev_gate_in;
    assign gate_fall = !gate_in && prev_gate_in;

    always_comb begin
        next_gate_state = gate_state;
        next_prev_gate_in = gate_in;
        case (gate_state)
            GATE_CLOSED: begin
                if (gate_rise) begin
                    next_gate_state = GATE_OPEN;
                end
            end
            GATE_OPEN: begin
                if (gate_fall) begin
                    next_gate_state = GATE_CLOSED;
                end
            end
            default: next_gate_state = GATE_CLOSED;
        endcase
        // New assignment waits for a fresh opening edge
        if (apply_params) begin
            next_gate_state = GATE_CLOSED;
            // History takes the new polarity, else a level reads as an edge
            next_prev_gate_in = aux_input ^ config_stage[CFG_GATE_INV_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            gate_state <= GATE_CLOSED;
            prev_gate_in <= 1'b0;
            prev_aux <= 1'b0;
            prev_zero <= 1'b0;
        end else begin
            gate_state <= next_gate_state;
            prev_gate_in <= next_prev_gate_in;
            prev_aux <= aux_input;
            prev_zero <= enc_zero;
        end
    end

    // Gate only matters in gate function; otherwise always counting
    assign counting = (func != FUNC_HARDWARE_GATE) || (gate_state == GATE_OPEN);

    // =========================================================
    // Counter
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;
    logic direction;
    logic next_direction;
    logic sync_load;

    always_comb begin
        sync_load = 1'b0;
        if (func == FUNC_SYNC_EDGE) begin
            sync_load = aux_input && !prev_aux;
        end else if (func == FUNC_SYNC_ENABLE) begin
            sync_load = enc_zero && !prev_zero && aux_input;
        end
        sync_load = sync_load && counting;
    end

    always_comb begin
        next_count = count;
        next_direction = direction;
        if (apply_params) begin
            next_count = load_stage;
        end else if (sync_load) begin
            next_count = load_stage;
        end else if (counting && steps.step) begin
            // Natural modulo arithmetic gives both wraps
            // Count held from previous closing
            if (steps.down) begin
                next_count = count - 25'h0000001;
            end else begin
                next_count = count + 25'h0000001;
            end
        end
        if (counting && steps.step) begin
            next_direction = steps.down;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            count <= LOAD_VALUE_RESET;
            direction <= 1'b0;
        end else begin
            count <= next_count;
            direction <= next_direction;
        end
    end

    // =========================================================
    // Feedback snapshot
    logic [DATA_W-1:0] feedback;
    logic [DATA_W-1:0] next_feedback;
    logic feedback_update;

    // Free-running mode refreshes per read so each read sees fresh data
    assign feedback_update = iso_enable ? iso_sample : rd_feedback;

    always_comb begin
        next_feedback = feedback;
        if (feedback_update) begin
            // One register captures everything together
            next_feedback[COUNT_W-1:0] = count;
            next_feedback[GATE_BIT] = counting;
            next_feedback[DIRECTION_BIT] = direction;
            next_feedback[INPUT_LEVEL_BIT] = aux_input;
            next_feedback[EXT_FAULT_BIT] = supply_short || signal_fault;
            next_feedback[PARAM_FAULT_BIT] = param_fault;
            next_feedback[ISO_BIT] = iso_enable && !param_fault;
            next_feedback[LIFE_BIT] = !feedback[LIFE_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feedback <= 32'h00000000;
        end else begin
            feedback <= next_feedback;
        end
    end

    // =========================================================
    // APB answer, zero wait states
    logic [DATA_W-1:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    always_comb begin
        next_pready = setup;
        next_pslverr = 1'b0;
        next_prdata = 32'h00000000;
        if (setup) begin
            case (paddr)
                FEEDBACK_OFS: begin
                    next_prdata = next_feedback;
                    // Feedback is read-only; a write is flagged
                    next_pslverr = pwrite;
                end
                CONFIG_OFS: next_prdata = {{(DATA_W-CFG_W){1'b0}}, config_stage};
                LOAD_VALUE_OFS: next_prdata = {{(DATA_W-COUNT_W){1'b0}}, load_stage};
                ASSIGN_OFS: next_prdata = 32'h00000000;
                default: next_pslverr = 1'b1;
            endcase
            if (pwrite) begin
                next_prdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end
endmodule : fast_encoder_counter
`default_nettype wire

// file: tb/fast_encoder_counter_chk.sv
// Port checker for the fast encoder counter
`timescale 1ns/1ps
`default_nettype none
module fast_encoder_counter_chk
    import fast_counter_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [fast_counter_pkg::ADDR_W-1:0] paddr,
    input wire logic [fast_counter_pkg::DATA_W-1:0] pwdata,
    input wire logic [fast_counter_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic enc_a,
    input wire logic enc_b,
    input wire logic enc_zero,
    input wire logic aux_input,
    input wire logic supply_short,
    input wire logic signal_fault,
    input wire logic iso_sample
);
    // =========================================================
    // Shadow of applied parameters and of the last read
    logic rd, wr, apply, bad;
    logic [CFG_W-1:0] stg, next_stg;
    logic [1:0] fn, next_fn;
    logic iso, next_iso, pf, next_pf, life, next_life, seen, next_seen;
    logic quiet, next_quiet, fresh, next_fresh;
    logic [31:0] word, next_word;
    logic [3:0] lvl, flt;
    assign rd = psel && penable && pready && !pwrite && paddr == FEEDBACK_OFS;
    assign wr = psel && penable && pready && pwrite;
    assign apply = wr && paddr == ASSIGN_OFS && pwdata[ASSIGN_BIT];
    assign bad = stg[CFG_GATE_INV_BIT] && stg[CFG_FUNC_LSB +: 2] != FUNC_HARDWARE_GATE;
    always_comb begin
        next_stg = (wr && paddr == CONFIG_OFS) ? pwdata[CFG_W-1:0] : stg;
        next_fn = (apply && !bad) ? stg[CFG_FUNC_LSB +: 2] : fn;
        next_iso = (apply && !bad) ? stg[CFG_ISO_BIT] : iso;
        next_pf = apply ? bad : pf;
        next_life = rd ? prdata[LIFE_BIT] : life;
        next_word = rd ? prdata : word;
        next_seen = !apply && (seen || rd);
        next_quiet = !iso_sample && (quiet || rd);
        next_fresh = !apply && (fresh || iso_sample);
    end
    // Input history runs through reset so levels held across it still count
    always_ff @(posedge clk) begin
        lvl <= {lvl[2:0], aux_input};
        flt <= {flt[2:0], supply_short | signal_fault};
        if (sys_rst) begin
            stg <= CONFIG_RESET;
            fn <= 2'h0;
            {iso, pf, life, seen, quiet, fresh} <= 6'h00;
            word <= 32'h0;
        end else begin
            stg <= next_stg;
            fn <= next_fn;
            {iso, pf, life, seen, quiet, fresh} <= {next_iso, next_pf, next_life, next_seen,
                next_quiet, next_fresh};
            word <= next_word;
        end
    end
    // =========================================================
    // Properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    life_flip_a: assert property (rd && seen && !iso |-> prdata[LIFE_BIT] != life)
        else $error("life bit did not toggle between reads");
    iso_hold_a: assert property (rd && iso && seen && quiet |-> prdata == word)
        else $error("iso snapshot changed without a sample");
    level_flag_a: assert property (rd && !iso && (lvl == 4'h0 || lvl == 4'hf)
        |-> prdata[INPUT_LEVEL_BIT] == lvl[0]) else $error("input flag wrong");
    ext_fault_a: assert property (rd && !iso && (flt == 4'h0 || flt == 4'hf)
        |-> prdata[EXT_FAULT_BIT] == flt[0]) else $error("external fault flag wrong");
    param_fault_a: assert property (rd && (!iso || fresh)
        |-> prdata[PARAM_FAULT_BIT] == pf) else $error("parameter fault flag wrong");
    iso_flag_a: assert property (rd && (!iso || fresh)
        |-> prdata[ISO_BIT] == (iso && !pf)) else $error("iso flag wrong");
    gate_run_a: assert property (rd && seen && !iso && fn != FUNC_HARDWARE_GATE
        |-> prdata[GATE_BIT]) else $error("counting not active without gate");
    ro_write_a: assert property ((psel && !penable && pwrite && paddr == FEEDBACK_OFS)
        ##1 penable |-> ##[0:4] (pready && pslverr)) else $error("feedback write accepted");
endmodule : fast_encoder_counter_chk
`default_nettype wire

// file: tb/enc_model.sv
// Behavioural incremental encoder driving quadrature and zero mark
`timescale 1ns/1ps
`default_nettype none
module enc_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic move,
    input wire logic back,
    input wire logic mark,
    output logic enc_a,
    output logic enc_b,
    output var logic enc_zero
);
    // =========================================================
    // Gray phase, so each quarter step moves exactly one line
    logic [1:0] phase, next_phase;
    always_comb begin
        next_phase = phase;
        if (move) begin
            next_phase = back ? phase - 2'h1 : phase + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase <= 2'h0;
            enc_zero <= 1'b0;
        end else begin
            phase <= next_phase;
            enc_zero <= mark;
        end
    end
    assign enc_a = phase[0] ^ phase[1];
    assign enc_b = phase[1];
endmodule : enc_model
`default_nettype wire

// file: tb/fast_encoder_counter_test.sv
// Self-checking bench for the fast encoder counter
`timescale 1ns/1ps
`default_nettype none
module fast_encoder_counter_test;
    import fast_counter_pkg::*;
    // =========================================================
    // Wiring and expectation tables
    logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, e;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, q, w1;
    logic enc_a, enc_b, enc_zero, aux_input, supply_short, signal_fault, iso_sample;
    logic move, back, mark;
    int error_cnt = 0;
    int checked = 0;
    localparam logic [31:0] M = 32'h7bffffff;
    localparam logic [CFG_W-1:0] CFGS [5] = '{7'h00, 7'h08, 7'h10, 7'h10, 7'h20};
    localparam logic [COUNT_W-1:0] LOADS [5] = '{25'h1fffffe, 25'h1fffffe, 25'h1fffffe,
        25'h0000001, 25'h0000005};
    localparam logic [4:0] BACKS = 5'b01000;
    localparam logic [31:0] EXPS [5] = '{32'h03ffffff, 32'h02000000, 32'h02000002,
        32'h07fffffd, 32'h06000004};
    fast_encoder_counter fast_encoder_counter_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b), .enc_zero(enc_zero),
        .aux_input(aux_input), .supply_short(supply_short), .signal_fault(signal_fault),
        .iso_sample(iso_sample));
    enc_model enc_model_inst (.clk(clk), .sys_rst(sys_rst), .move(move), .back(back),
        .mark(mark), .enc_a(enc_a), .enc_b(enc_b), .enc_zero(enc_zero));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // =========================================================
    // Tasks
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // No wait is assumed: the answer is awaited, bounded only by the watchdog
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic fb(input logic [31:0] exp, input logic [31:0] m);
        apb(1'b0, FEEDBACK_OFS, 32'h0);
        check("feedback", q & m, exp);
        check("read error", {31'h0, e}, 32'h0);
    endtask : fb
    task automatic setup(input logic [CFG_W-1:0] c, input logic [COUNT_W-1:0] l);
        apb(1'b1, LOAD_VALUE_OFS, {7'h00, l});
        apb(1'b1, CONFIG_OFS, {25'h0, c});
        apb(1'b1, ASSIGN_OFS, 32'h1);
    endtask : setup
    task automatic turn(input logic b);
        repeat (4) begin
            @(posedge clk);
            move <= 1'b1;
            back <= b;
            @(posedge clk);
            move <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : turn
    task automatic drive(input logic [4:0] v);
        @(posedge clk);
        {aux_input, supply_short, signal_fault, iso_sample, mark} <= v;
        @(posedge clk);
        {iso_sample, mark} <= 2'b00;
        repeat (6) @(posedge clk);
    endtask : drive
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out
    // =========================================================
    // Scenarios
    initial begin
        {sys_rst, psel, penable, pwrite, move, back, mark} = 7'h40;
        {aux_input, supply_short, signal_fault, iso_sample} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        fb(32'h02000000, M);
        for (int i = 0; i < 5; i++) begin
            setup(CFGS[i], LOADS[i]);
            fb({7'h01, LOADS[i]}, M);
            turn(BACKS[i]);
            fb(EXPS[i], 32'h7fffffff);
        end
        setup(7'h01, 25'h10);
        turn(1'b0);
        fb(32'h00000010, M);
        drive(5'h10);
        fb(32'h0a000010, M);
        turn(1'b0);
        fb(32'h0a000011, M);
        drive(5'h00);
        turn(1'b0);
        fb(32'h00000011, M);
        drive(5'h10);
        turn(1'b0);
        fb(32'h0a000012, M);
        drive(5'h00);
        setup(7'h05, 25'h10);
        fb(32'h00000010, M);
        drive(5'h10);
        fb(32'h08000010, M);
        drive(5'h00);
        fb(32'h02000010, M);
        setup(7'h02, 25'h20);
        turn(1'b0);
        drive(5'h10);
        fb(32'h0a000020, M);
        turn(1'b0);
        drive(5'h00);
        drive(5'h10);
        fb(32'h0a000020, M);
        drive(5'h00);
        setup(7'h03, 25'h30);
        turn(1'b0);
        drive(5'h01);
        fb(32'h02000031, M);
        drive(5'h10);
        drive(5'h11);
        fb(32'h0a000030, M);
        apb(1'b1, CONFIG_OFS, 32'h4);
        apb(1'b1, ASSIGN_OFS, 32'h1);
        fb(32'h2a000030, M);
        setup(7'h00, 25'h0);
        fb(32'h0a000000, M);
        drive(5'h18);
        fb(32'h1a000000, M);
        drive(5'h14);
        fb(32'h1a000000, M);
        drive(5'h10);
        fb(32'h0a000000, M);
        setup(7'h40, 25'h0);
        drive(5'h12);
        fb(32'h4a000000, M);
        w1 = q;
        turn(1'b0);
        fb(32'h4a000000, M);
        check("snapshot", q, w1);
        drive(5'h12);
        fb(32'h4a000001, 32'h7fffffff);
        check("life", {31'h0, q[31]}, {31'h0, ~w1[31]});
        apb(1'b1, FEEDBACK_OFS, 32'hffffffff);
        check("write error", {31'h0, e}, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped error", {31'h0, e}, 32'h1);
        close_out();
    end
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        close_out();
    end
endmodule : fast_encoder_counter_test
bind fast_encoder_counter fast_encoder_counter_chk fast_encoder_counter_chk_inst (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a),
    .enc_b(enc_b), .enc_zero(enc_zero), .aux_input(aux_input), .supply_short(supply_short),
    .signal_fault(signal_fault), .iso_sample(iso_sample));
`default_nettype wire
